// *** bench/tsfc_host.sv ***
`default_nettype none
// ****************
// Bus host model
// ****************
module tsfc_host
	import tsfc_pkg::*;
(
	input wire logic sys_clk, // Clock
	output var tsfc_byte_t byte_in // Byte strobe to the registers
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ptr;
	// Line idle from time zero
	initial
	begin
		byte_in = '0;
	end
	// Address byte, then data to ascending registers, no gaps
	task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
		ptr = a;
		@(posedge sys_clk);
		byte_in <= {1'b1, 1'b1, a};
		foreach (d[i])
		begin
			@(posedge sys_clk);
			byte_in <= {2'b10, d[i] & (ptr == TSFC_ADDR_GAIN_STANDBY ? 8'hdf : 8'hff)};
			ptr = ptr + 8'h01;
		end
		@(posedge sys_clk);
		byte_in <= {2'b00, ~byte_in.data}; // Released line shows no stale byte
	endtask : wr
endmodule : tsfc_host
`default_nettype wire

// *** bench/tsfc_regs_bench.sv ***
`default_nettype none
// ****************
// Register group bench
// ****************
module tsfc_regs_bench
	import tsfc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic rst_n;
	logic vas_pump_high;
	logic [4:0] vas_band;
	logic byte_ack;
	tsfc_byte_t byte_in;
	tsfc_ctrl_t ctrl;
	logic [7:0] sh [5];
	int num_errors = 0;
	int compares = 0;
	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;
	tsfc_regs tsfc_regs_inst (.sys_clk(sys_clk), .rst_n(rst_n), .byte_in(byte_in),
		.vas_pump_high(vas_pump_high), .vas_band(vas_band), .byte_ack(byte_ack), .ctrl(ctrl));
	tsfc_host tsfc_host_inst (.sys_clk(sys_clk), .byte_in(byte_in));
	// Expected lines from shadow copy; autoselect overrides band, pump source bit overrides pump level
	function automatic tsfc_ctrl_t expc();
		logic au;
		au = sh[1][2];
		return {sh[0][7:6], sh[0][6] ? vas_pump_high : sh[0][5], au ? vas_band : sh[1][7:3],
			au, sh[1][1:0] & {2{!au}}, sh[2], sh[3][7], sh[3][5], sh[3][3:0], sh[4][6:0],
			!(sh[3][7] | (|sh[4][6:4])), !(sh[3][7] | (|sh[4][3:0]))};
	endfunction : expc
	task automatic shreset();
		sh = '{8'hc0, 8'hcc, 8'h4b, 8'h00, 8'h00}; // 0x4b gives the 22.27MHz corner
	endtask : shreset
	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// Burst write; shadow keeps only the meaningful bits
	task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
		logic [7:0] m [5];
		int k;
		m = '{8'he0, 8'hff, 8'hff, 8'haf, 8'h7f};
		tsfc_host_inst.wr(a, d);
		foreach (d[i])
		begin
			k = int'(a) + i - 6;
			if (k >= 0 && k <= 4) sh[k] = d[i] & m[k];
		end
		repeat (2) @(posedge sys_clk);
		#1;
	endtask : wr
	task automatic t_burst();
		wr(8'h06, {8'h3f, 8'h53, 8'h0c, 8'h5f, 8'hff, 8'h55});
		check("burst", ctrl, expc());
	endtask : t_burst
	task automatic t_codes();
		for (int i = 0; i < 7; i++)
		begin
			wr(8'h0a, {8'h01 << i});
			check("power_down", ctrl, expc());
		end
		wr(8'h09, {8'h80, 8'h00});
		check("standby", ctrl, expc());
		wr(8'h09, {8'h00, 8'h00, 8'h0c});
		check("restore", ctrl, expc());
		wr(8'h08, {8'hff});
		check("corner_top", ctrl, expc());
	endtask : t_codes
	task automatic t_autoselect();
		wr(8'h06, {8'hc0, 8'hcf});
		for (int i = 0; i < 4; i++)
		begin
			@(posedge sys_clk);
			vas_band <= 5'(i * 7);
			vas_pump_high <= i[0];
			repeat (2) @(posedge sys_clk);
			#1;
			check("autoselect", ctrl, expc());
		end
	endtask : t_autoselect
	task automatic t_mid_reset();
		wr(8'h08, {8'h20, 8'h85});
		check("pre_reset", ctrl, expc());
		@(posedge sys_clk);
		rst_n <= 1'b0;
		@(posedge sys_clk);
		rst_n <= 1'b1;
		shreset();
		repeat (2) @(posedge sys_clk);
		#1;
		check("mid_reset", ctrl, expc());
	endtask : t_mid_reset
	task automatic results();
		if (num_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results
	// Main sequence
	initial
	begin
		rst_n = 1'b0;
		vas_pump_high = 1'b0;
		vas_band = 5'h19;
		shreset();
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		check("reset", ctrl, expc());
		t_burst();
		t_codes();
		t_autoselect();
		t_mid_reset();
		results();
	end
	// Hang guard
	initial
	begin
		repeat (100000) @(posedge sys_clk);
		num_errors++;
		results();
	end
endmodule : tsfc_regs_bench
`default_nettype wire

// *** bench/tsfc_regs_properties.sv ***
`default_nettype none
// ****************
// Register group checks
// ****************
module tsfc_regs_properties
	import tsfc_pkg::*;
(
	input wire logic sys_clk, // Clock
	input wire logic rst_n, // Reset, active low
	input wire tsfc_byte_t byte_in, // Received byte
	input wire logic vas_pump_high, // Autoselect pump level
	input wire logic [4:0] vas_band, // Autoselect band
	input wire logic byte_ack, // Byte acknowledge
	input wire tsfc_ctrl_t ctrl // Control lines
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Address byte aimed at the filter corner, then one data byte
	sequence s_corner_addr;
		byte_in.valid && byte_in.is_addr && byte_in.data == TSFC_ADDR_FILTER_CORNER;
	endsequence
	sequence s_data_byte;
		byte_in.valid && !byte_in.is_addr;
	endsequence
	a_ack_same_cycle: assert property (byte_ack == byte_in.valid)
		else $error("byte_ack differs from valid");
	a_corner_lands: assert property (s_corner_addr ##1 s_data_byte |-> ##2
		ctrl.filter_corner_code == $past(byte_in.data, 2))
		else $error("corner code not written");
	// Quiet bus must leave the filter corner and baseband gain codes alone
	a_idle_holds: assert property (!byte_in.valid ##2 1'b1 |->
		$stable(ctrl.filter_corner_code) && $stable(ctrl.baseband_gain_code))
		else $error("settings moved without a write");
	a_auto_band: assert property (ctrl.auto_band_enable && $past(rst_n) |->
		ctrl.oscillator_band_select == $past(vas_band))
		else $error("band not from search");
	a_auto_pump: assert property (ctrl.pump_current_source && $past(rst_n) |->
		ctrl.pump_current_level == $past(vas_pump_high))
		else $error("pump level not from search");
	a_auto_conv_off: assert property (ctrl.auto_band_enable |->
		!ctrl.tune_conv_latch && !ctrl.tune_conv_read_enable)
		else $error("converter active in autoselect");
	a_synth_gate: assert property (ctrl.synth_enable ==
		!(ctrl.soft_standby || ctrl.loop_off || ctrl.divider_off || ctrl.osc_off))
		else $error("synthesizer enable wrong");
	a_path_gate: assert property (ctrl.signal_path_enable == !(ctrl.soft_standby ||
		ctrl.baseband_off || ctrl.rf_mixer_off || ctrl.rf_amp_off || ctrl.front_end_off))
		else $error("signal path enable wrong");
	a_reset_image: assert property ($rose(rst_n) |-> ctrl.osc_post_divide_select &&
		ctrl.filter_corner_code == 8'h4b && ctrl.baseband_gain_code == 4'h0)
		else $error("reset image wrong");
endmodule : tsfc_regs_properties
bind tsfc_regs tsfc_regs_properties tsfc_regs_properties_inst (.sys_clk(sys_clk), .rst_n(rst_n),
	.byte_in(byte_in), .vas_pump_high(vas_pump_high), .vas_band(vas_band),
	.byte_ack(byte_ack), .ctrl(ctrl));
`default_nettype wire

// *** hdl/tsfc_addr_ptr.sv ***
`default_nettype none

module tsfc_addr_ptr
	import tsfc_pkg::*;
(
	input wire logic sys_clk, // System clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire tsfc_byte_t byte_in, // Byte from two-wire front end
	output logic wr_en, // Data byte write strobe
	output logic [7:0] wr_addr, // Register address of this write
	output logic [7:0] wr_data // Data byte
);

	// ******************************************************************
	// Address pointer
	// ******************************************************************
	logic [7:0] ptr;
	logic [7:0] next_ptr;

	// Address byte loads, each data byte steps on
	always_comb
	begin
		next_ptr = ptr;
		if (byte_in.valid && byte_in.is_addr)
			next_ptr = byte_in.data;
		else if (byte_in.valid)
			next_ptr = ptr + 8'h01;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			ptr <= 8'h00;
		else
			ptr <= next_ptr;
	end

	// Write goes to the pointer as it stood before the step
	assign wr_en = byte_in.valid && !byte_in.is_addr;
	assign wr_addr = ptr;
	assign wr_data = byte_in.data;

endmodule : tsfc_addr_ptr

`default_nettype wire

// *** hdl/tsfc_pkg.sv ***
// Behaviour
// - Loop setup bit 7 picks oscillator post-divide, 0 = /2, 1 = /4; reset 1.
// - Loop setup bit 6 picks pump current source, else bit 5 sets level; reset 1.
// - Oscillator band field bits 7..3, reset 11001, manual band or search start.
// - Oscillator bit 2 enables automatic band selection; reset 1.
// - With autoselect off, oscillator bit 1 latches tuning converter result; reset 0.
// - With autoselect off, oscillator bit 0 enables tuning converter read; reset 0.
// - Filter corner code, 8 bits, corner = 4MHz + (code - 12) * 290kHz.
// - Filter corner code resets to the value giving about 22.27MHz.
// - Standby bit 7 stops signal path and synthesizer; bus and crystal stay on.
// - Baseband gain bits 3..0, about 1dB per step, reset 0000.
// - Power-down bits 6..0 shut individual analog blocks; all reset 0.
// - After each acknowledged data byte the register address advances.
`default_nettype none

package tsfc_pkg;

	// ******************************************************************
	// Register addresses
	// ******************************************************************
	localparam logic [7:0] TSFC_ADDR_LOOP_SETUP = 8'h06;
	localparam logic [7:0] TSFC_ADDR_OSC_SELECT = 8'h07;
	localparam logic [7:0] TSFC_ADDR_FILTER_CORNER = 8'h08;
	localparam logic [7:0] TSFC_ADDR_GAIN_STANDBY = 8'h09;
	localparam logic [7:0] TSFC_ADDR_POWER_DOWN = 8'h0a;

	// ******************************************************************
	// Reset values and writable-bit masks
	// ******************************************************************
	localparam logic [7:0] TSFC_RST_LOOP_SETUP = 8'hc0;
	localparam logic [7:0] TSFC_RST_OSC_SELECT = 8'hcc;
	localparam logic [7:0] TSFC_RST_FILTER_CORNER = 8'h4b; // 75: 4 + 63 * 0.29 = 22.27MHz
	localparam logic [7:0] TSFC_RST_GAIN_STANDBY = 8'h00;
	localparam logic [7:0] TSFC_RST_POWER_DOWN = 8'h00;
	localparam logic [7:0] TSFC_MASK_LOOP_SETUP = 8'he0;
	localparam logic [7:0] TSFC_MASK_OSC_SELECT = 8'hff;
	localparam logic [7:0] TSFC_MASK_FILTER_CORNER = 8'hff;
	localparam logic [7:0] TSFC_MASK_GAIN_STANDBY = 8'haf;
	localparam logic [7:0] TSFC_MASK_POWER_DOWN = 8'h7f;

	// ******************************************************************
	// Field positions
	// ******************************************************************
	localparam int TSFC_BIT_POST_DIVIDE = 7;
	localparam int TSFC_BIT_PUMP_SOURCE = 6;
	localparam int TSFC_BIT_PUMP_LEVEL = 5;
	localparam int TSFC_BAND_MSB = 7;
	localparam int TSFC_BAND_LSB = 3;
	localparam int TSFC_BIT_AUTO_BAND = 2;
	localparam int TSFC_BIT_CONV_LATCH = 1;
	localparam int TSFC_BIT_CONV_READ = 0;
	localparam int TSFC_BIT_STANDBY = 7;
	localparam int TSFC_BIT_FACTORY_PD = 5;
	localparam int TSFC_GAIN_MSB = 3;
	localparam int TSFC_BIT_LOOP_OFF = 6;
	localparam int TSFC_BIT_DIVIDER_OFF = 5;
	localparam int TSFC_BIT_OSC_OFF = 4;
	localparam int TSFC_BIT_BASEBAND_OFF = 3;
	localparam int TSFC_BIT_RF_MIXER_OFF = 2;
	localparam int TSFC_BIT_RF_AMP_OFF = 1;
	localparam int TSFC_BIT_FRONT_END_OFF = 0;

	// ******************************************************************
	// Carriers
	// ******************************************************************
	// One received byte from the two-wire front end
	typedef struct packed {
		logic valid;     // Byte strobe, one cycle
		logic is_addr;   // First byte after the slave address
		logic [7:0] data;
	} tsfc_byte_t;

	// Analog control lines
	typedef struct packed {
		logic osc_post_divide_select;
		logic pump_current_source;
		logic pump_current_level;
		logic [4:0] oscillator_band_select;
		logic auto_band_enable;
		logic tune_conv_latch;
		logic tune_conv_read_enable;
		logic [7:0] filter_corner_code;
		logic soft_standby;
		logic factory_powerdown;
		logic [3:0] baseband_gain_code;
		logic loop_off;
		logic divider_off;
		logic osc_off;
		logic baseband_off;
		logic rf_mixer_off;
		logic rf_amp_off;
		logic front_end_off;
		logic synth_enable;
		logic signal_path_enable;
	} tsfc_ctrl_t;

endpackage : tsfc_pkg

`default_nettype wire

// *** hdl/tsfc_regs.sv ***
`default_nettype none

module tsfc_regs
	import tsfc_pkg::*;
(
	input wire logic sys_clk, // System clock, 100 MHz
	input wire logic rst_n, // Synchronous reset, active low
	input wire tsfc_byte_t byte_in, // Received byte from the two-wire front end
	input wire logic vas_pump_high, // Pump level chosen by autoselect logic
	input wire logic [4:0] vas_band, // Band chosen by autoselect search
	output logic byte_ack, // Acknowledge for the current byte
	output tsfc_ctrl_t ctrl // Analog control lines
);

	// ******************************************************************
	// Write path
	// ******************************************************************
	// Byte routed through the address pointer
	logic wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;

	tsfc_addr_ptr tsfc_addr_ptr_inst
	(
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.byte_in(byte_in),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data)
	);

	// Every byte is taken; outside this group the other banks own it
	assign byte_ack = byte_in.valid;

	// Merge a write into a register, touching only writable bits
	function automatic logic [7:0] tsfc_merge(input logic [7:0] old, input logic [7:0] data,
		input logic [7:0] mask);
		tsfc_merge = (old & ~mask) | (data & mask);
	endfunction : tsfc_merge

	// ******************************************************************
	// Limitations
	// ******************************************************************
	// Pointer wraps at the top of the address space
	// Bytes aimed outside this group are acked and dropped; other banks own them
	// Factory bit is stored and passed on; the host must keep it clear
	// No read path, so a host in doubt must simply rewrite

	// ******************************************************************
	// Register storage
	// ******************************************************************
	// Stored bytes; don't-care positions keep their reset level
	logic [7:0] loop_setup;
	logic [7:0] oscillator_select;
	logic [7:0] filter_corner;
	logic [7:0] gain_standby_ctrl;
	logic [7:0] block_power_down;

	// Next values
	logic [7:0] next_loop_setup;
	logic [7:0] next_oscillator_select;
	logic [7:0] next_filter_corner;
	logic [7:0] next_gain_standby_ctrl;
	logic [7:0] next_block_power_down;

	// Address decode; masks drop the don't-care positions so they read stable
	always_comb
	begin
		next_loop_setup = loop_setup;
		next_oscillator_select = oscillator_select;
		next_filter_corner = filter_corner;
		next_gain_standby_ctrl = gain_standby_ctrl;
		next_block_power_down = block_power_down;

		// Only a data byte may change a register
		if (wr_en)
		begin
			unique case (wr_addr)
				TSFC_ADDR_LOOP_SETUP:
					next_loop_setup = tsfc_merge(loop_setup, wr_data,
						TSFC_MASK_LOOP_SETUP);
				TSFC_ADDR_OSC_SELECT:
					next_oscillator_select = tsfc_merge(oscillator_select, wr_data,
						TSFC_MASK_OSC_SELECT);
				TSFC_ADDR_FILTER_CORNER:
					next_filter_corner = tsfc_merge(filter_corner, wr_data,
						TSFC_MASK_FILTER_CORNER);
				TSFC_ADDR_GAIN_STANDBY:
					next_gain_standby_ctrl = tsfc_merge(gain_standby_ctrl, wr_data,
						TSFC_MASK_GAIN_STANDBY);
				TSFC_ADDR_POWER_DOWN:
					next_block_power_down = tsfc_merge(block_power_down, wr_data,
						TSFC_MASK_POWER_DOWN);
				default:
					next_loop_setup = loop_setup; // Other banks, not held here
			endcase
		end
	end

	// Power-on defaults
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			loop_setup <= TSFC_RST_LOOP_SETUP;
			oscillator_select <= TSFC_RST_OSC_SELECT;
			filter_corner <= TSFC_RST_FILTER_CORNER;
			gain_standby_ctrl <= TSFC_RST_GAIN_STANDBY;
			block_power_down <= TSFC_RST_POWER_DOWN;
		end
		else
		begin
			loop_setup <= next_loop_setup;
			oscillator_select <= next_oscillator_select;
			filter_corner <= next_filter_corner;
			gain_standby_ctrl <= next_gain_standby_ctrl;
			block_power_down <= next_block_power_down;
		end
	end

	// ******************************************************************
	// Control line decode
	// ******************************************************************
	tsfc_ctrl_t next_ctrl;
	logic auto_on;
	logic standby;

	// Mode bits shared by several lines
	assign auto_on = oscillator_select[TSFC_BIT_AUTO_BAND];
	assign standby = gain_standby_ctrl[TSFC_BIT_STANDBY];

	// Fields map straight to analog lines; no read path exists
	always_comb
	begin
		next_ctrl = '0;
		// Divide by 4 when set, by 2 when clear
		next_ctrl.osc_post_divide_select = loop_setup[TSFC_BIT_POST_DIVIDE];
		next_ctrl.pump_current_source = loop_setup[TSFC_BIT_PUMP_SOURCE];

		// Autoselect owns the pump level when the source bit is set
		if (loop_setup[TSFC_BIT_PUMP_SOURCE])
			next_ctrl.pump_current_level = vas_pump_high;
		else
			next_ctrl.pump_current_level = loop_setup[TSFC_BIT_PUMP_LEVEL];

		// Manual band, or search result once autoselect runs from the start band
		if (auto_on)
			next_ctrl.oscillator_band_select = vas_band;
		else
			next_ctrl.oscillator_band_select =
				oscillator_select[TSFC_BAND_MSB:TSFC_BAND_LSB];
		next_ctrl.auto_band_enable = auto_on;

		// Converter controls only mean something with autoselect off
		next_ctrl.tune_conv_latch = !auto_on
			&& oscillator_select[TSFC_BIT_CONV_LATCH];
		next_ctrl.tune_conv_read_enable = !auto_on
			&& oscillator_select[TSFC_BIT_CONV_READ];

		// Corner code drives the filter as written
		next_ctrl.filter_corner_code = filter_corner;

		// Gain and standby lines
		next_ctrl.soft_standby = standby;
		// Passed through as written; host is expected to keep it clear
		next_ctrl.factory_powerdown = gain_standby_ctrl[TSFC_BIT_FACTORY_PD];
		next_ctrl.baseband_gain_code = gain_standby_ctrl[TSFC_GAIN_MSB:0];

		// One shutdown line per analog block
		next_ctrl.loop_off = block_power_down[TSFC_BIT_LOOP_OFF];
		next_ctrl.divider_off = block_power_down[TSFC_BIT_DIVIDER_OFF];
		next_ctrl.osc_off = block_power_down[TSFC_BIT_OSC_OFF];
		next_ctrl.baseband_off = block_power_down[TSFC_BIT_BASEBAND_OFF];
		next_ctrl.rf_mixer_off = block_power_down[TSFC_BIT_RF_MIXER_OFF];
		next_ctrl.rf_amp_off = block_power_down[TSFC_BIT_RF_AMP_OFF];
		next_ctrl.front_end_off = block_power_down[TSFC_BIT_FRONT_END_OFF];

		// Standby gates synthesizer and signal path; bus and crystal untouched
		next_ctrl.synth_enable = !standby
			&& !block_power_down[TSFC_BIT_LOOP_OFF]
			&& !block_power_down[TSFC_BIT_DIVIDER_OFF]
			&& !block_power_down[TSFC_BIT_OSC_OFF];
		next_ctrl.signal_path_enable = !standby
			&& !block_power_down[TSFC_BIT_BASEBAND_OFF]
			&& !block_power_down[TSFC_BIT_RF_MIXER_OFF]
			&& !block_power_down[TSFC_BIT_RF_AMP_OFF]
			&& !block_power_down[TSFC_BIT_FRONT_END_OFF];
	end

	// Registered lines avoid glitches on the analog side, costing one cycle
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			// Image of the stored defaults; search inputs are not trusted in reset
			ctrl.osc_post_divide_select <= TSFC_RST_LOOP_SETUP[TSFC_BIT_POST_DIVIDE];
			ctrl.pump_current_source <= TSFC_RST_LOOP_SETUP[TSFC_BIT_PUMP_SOURCE];
			ctrl.pump_current_level <= TSFC_RST_LOOP_SETUP[TSFC_BIT_PUMP_LEVEL];
			ctrl.oscillator_band_select <=
				TSFC_RST_OSC_SELECT[TSFC_BAND_MSB:TSFC_BAND_LSB];
			ctrl.auto_band_enable <= TSFC_RST_OSC_SELECT[TSFC_BIT_AUTO_BAND];
			ctrl.tune_conv_latch <= TSFC_RST_OSC_SELECT[TSFC_BIT_CONV_LATCH];
			ctrl.tune_conv_read_enable <= TSFC_RST_OSC_SELECT[TSFC_BIT_CONV_READ];
			ctrl.filter_corner_code <= TSFC_RST_FILTER_CORNER;
			ctrl.soft_standby <= TSFC_RST_GAIN_STANDBY[TSFC_BIT_STANDBY];
			ctrl.factory_powerdown <= TSFC_RST_GAIN_STANDBY[TSFC_BIT_FACTORY_PD];
			ctrl.baseband_gain_code <= TSFC_RST_GAIN_STANDBY[TSFC_GAIN_MSB:0];
			ctrl.loop_off <= TSFC_RST_POWER_DOWN[TSFC_BIT_LOOP_OFF];
			ctrl.divider_off <= TSFC_RST_POWER_DOWN[TSFC_BIT_DIVIDER_OFF];
			ctrl.osc_off <= TSFC_RST_POWER_DOWN[TSFC_BIT_OSC_OFF];
			ctrl.baseband_off <= TSFC_RST_POWER_DOWN[TSFC_BIT_BASEBAND_OFF];
			ctrl.rf_mixer_off <= TSFC_RST_POWER_DOWN[TSFC_BIT_RF_MIXER_OFF];
			ctrl.rf_amp_off <= TSFC_RST_POWER_DOWN[TSFC_BIT_RF_AMP_OFF];
			ctrl.front_end_off <= TSFC_RST_POWER_DOWN[TSFC_BIT_FRONT_END_OFF];
			ctrl.synth_enable <= 1'b1;
			ctrl.signal_path_enable <= 1'b1;
		end
		else
		begin
			ctrl <= next_ctrl;
		end
	end

endmodule : tsfc_regs

`default_nettype wire
